// [shared/gpr_pkg.sv]
// Purpose: constants and types for the four-pin port and input routing block
// Assumes: APB slave with 32-bit data, one register per aligned word
// Notes: register offsets are byte addresses
// Summary of operation
// - port has four pins, one bit each
// - direction one turns the output driver off
// - direction zero drives the latch value out
// - data reads pins, data writes go to latch
// - data write samples pins, merges, stores latch
// - direction controls drivers even for analog pins
// - top direction bit reads one, read-only
// - open-drain bit makes output sink only
// - two-wire module forces its pin open-drain
// - slew bit selects limited edge rate
// - threshold bit picks Schmitt or TTL sensing
// - analog-select forces digital reads to zero
// - analog-select leaves digital output unaffected
// - analog-select bits reset to one
// - pull-up enable per pin, independent
// - route register: six-bit field, bits 7-6 zero
// - each peripheral input has own route register
package gpr_pkg;

    localparam int PIN_COUNT = 4;
    localparam int ROUTE_W = 6;
    localparam int ROUTE_PINS = 64;
    localparam int PORT_STRIDE = 8;
    // this port is the fifth port of the device, so its pins start at code 32
    localparam int PORT_INDEX = 4;
    localparam int ADDR_W = 12;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_PIN_LEVEL = 12'h000;
    localparam logic [ADDR_W-1:0] OFS_DIRECTION = 12'h004;
    localparam logic [ADDR_W-1:0] OFS_OUTPUT_LATCH = 12'h008;
    localparam logic [ADDR_W-1:0] OFS_ANALOG_SELECT = 12'h00C;
    localparam logic [ADDR_W-1:0] OFS_PULLUP_ENABLE = 12'h010;
    localparam logic [ADDR_W-1:0] OFS_OPEN_DRAIN = 12'h014;
    localparam logic [ADDR_W-1:0] OFS_SLEW_LIMIT = 12'h018;
    localparam logic [ADDR_W-1:0] OFS_INPUT_THRESHOLD = 12'h01C;
    localparam logic [ADDR_W-1:0] OFS_EXT_INT_ROUTE = 12'h020;
    localparam logic [ADDR_W-1:0] OFS_TIMER_CLK_ROUTE = 12'h024;
    localparam logic [ADDR_W-1:0] OFS_SERIAL_RX_ROUTE = 12'h028;

    // reset values
    localparam logic [PIN_COUNT-1:0] RST_DIRECTION = 4'hF;
    localparam logic [PIN_COUNT-1:0] RST_OUTPUT_LATCH = 4'h0;
    localparam logic [PIN_COUNT-1:0] RST_ANALOG_SELECT = 4'hF;
    localparam logic [PIN_COUNT-1:0] RST_PULLUP_ENABLE = 4'h0;
    localparam logic [PIN_COUNT-1:0] RST_OPEN_DRAIN = 4'h0;
    localparam logic [PIN_COUNT-1:0] RST_SLEW_LIMIT = 4'hF;
    localparam logic [PIN_COUNT-1:0] RST_INPUT_THRESHOLD = 4'hF;
    localparam logic [ROUTE_W-1:0] RST_EXT_INT_ROUTE = 6'h00;
    localparam logic [ROUTE_W-1:0] RST_TIMER_CLK_ROUTE = 6'h04;
    localparam logic [ROUTE_W-1:0] RST_SERIAL_RX_ROUTE = 6'h17;

    // direction bit that is fixed at one
    localparam int DIR_FIXED_BIT = PIN_COUNT - 1;
    localparam logic [PIN_COUNT-1:0] DIR_FIXED_MASK = 4'h8;

    // pad controls for every pin of the port, one bit per pin in each field
    typedef struct packed {
        logic [PIN_COUNT-1:0] drive;
        logic [PIN_COUNT-1:0] drive_en;
        logic [PIN_COUNT-1:0] pullup_en;
        logic [PIN_COUNT-1:0] slew_limit;
    } gpr_pad_ctrl_t;

    // both sensed levels of every pin, one per input buffer type
    typedef struct packed {
        logic [PIN_COUNT-1:0] schmitt;
        logic [PIN_COUNT-1:0] ttl;
    } gpr_pad_sense_t;

endpackage

// [hdl/gpr_port.sv]
// Purpose: four-pin port with per-pin controls and peripheral input routing
// Assumes: pin sense inputs are synchronous to pclk; zero-wait APB slave
// Notes: other device pins arrive on route_pins; this port fills its own slot
//
// Register access over APB and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module gpr_port #(
    parameter logic [gpr_pkg::ROUTE_W-1:0] EXT_INT_ROUTE_RST = gpr_pkg::RST_EXT_INT_ROUTE,
    parameter logic [gpr_pkg::ROUTE_W-1:0] TIMER_CLK_ROUTE_RST = gpr_pkg::RST_TIMER_CLK_ROUTE,
    parameter logic [gpr_pkg::ROUTE_W-1:0] SERIAL_RX_ROUTE_RST = gpr_pkg::RST_SERIAL_RX_ROUTE
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [gpr_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire gpr_pkg::gpr_pad_sense_t pad_sense,
    output gpr_pkg::gpr_pad_ctrl_t pad_ctrl,
    input wire logic [gpr_pkg::PIN_COUNT-1:0] twi_own,
    input wire logic [gpr_pkg::PIN_COUNT-1:0] twi_drive_low,
    output logic [gpr_pkg::PIN_COUNT-1:0] ioc_level,
    input wire logic [gpr_pkg::ROUTE_PINS-1:0] route_pins,
    output logic ext_interrupt_in,
    output logic timer_clock_in,
    output logic serial_rx_in
);
    import gpr_pkg::*;

    logic [PIN_COUNT-1:0] direction_q; // one bit per pin in every control
    logic [PIN_COUNT-1:0] latch_q;
    logic [PIN_COUNT-1:0] analog_q;
    logic [PIN_COUNT-1:0] pullup_q;
    logic [PIN_COUNT-1:0] open_drain_q;
    logic [PIN_COUNT-1:0] slew_q;
    logic [PIN_COUNT-1:0] threshold_q;
    logic [ROUTE_W-1:0] ext_int_route_q;
    logic [ROUTE_W-1:0] timer_clk_route_q;
    logic [ROUTE_W-1:0] serial_rx_route_q;
    logic [PIN_COUNT-1:0] sensed;
    logic [PIN_COUNT-1:0] digital_in;
    logic [PIN_COUNT-1:0] latch_d;
    logic [ROUTE_PINS-1:0] all_pins;
    logic wr_en;
    logic rd_en;
    logic addr_hit;
    logic lane0;

    // one-cycle access phase; every transfer is taken at the first access edge
    assign pready = 1'b1;
    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & penable & ~pwrite;
    assign lane0 = pstrb[0];

    // threshold choice decides both the port read and the change detector
    always_comb begin
        for (int i = 0; i < PIN_COUNT; i++) begin
            sensed[i] = threshold_q[i] ? pad_sense.schmitt[i] : pad_sense.ttl[i];
        end
    end
    assign ioc_level = sensed;

    // analog pins read as zero on the port read and the routed inputs; ioc_level is not masked
    assign digital_in = sensed & ~analog_q;

    // read-modify-write: pins sampled, strobed lane replaced, result to latch
    always_comb begin
        latch_d = digital_in;
        if (lane0) begin
            latch_d = pwdata[PIN_COUNT-1:0];
        end
    end

    // pad drive; analog-select never enters this path, so analog pins still drive
    always_comb begin
        for (int i = 0; i < PIN_COUNT; i++) begin
            if (twi_own[i]) begin
                // the two-wire module only ever pulls low, whatever open_drain_q says
                pad_ctrl.drive[i] = 1'b0;
                pad_ctrl.drive_en[i] = twi_drive_low[i];
            end else begin
                pad_ctrl.drive[i] = latch_q[i];
                // driver off for inputs, and for a high level when open-drain
                pad_ctrl.drive_en[i] = ~direction_q[i]
                    & ~(open_drain_q[i] & latch_q[i]);
            end
        end
        pad_ctrl.pullup_en = pullup_q;
        pad_ctrl.slew_limit = slew_q;
    end

    // direction; the top bit is tied to one and ignores writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            direction_q <= RST_DIRECTION;
        end else if (wr_en && lane0 && paddr == OFS_DIRECTION) begin
            direction_q <= pwdata[PIN_COUNT-1:0] | DIR_FIXED_MASK;
        end
    end

    // output latch, written directly or through the data register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latch_q <= RST_OUTPUT_LATCH;
        end else if (wr_en && paddr == OFS_PIN_LEVEL) begin
            latch_q <= latch_d;
        end else if (wr_en && lane0 && paddr == OFS_OUTPUT_LATCH) begin
            latch_q <= pwdata[PIN_COUNT-1:0];
        end
    end

    // analog select comes up all set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            analog_q <= RST_ANALOG_SELECT;
        end else if (wr_en && lane0 && paddr == OFS_ANALOG_SELECT) begin
            analog_q <= pwdata[PIN_COUNT-1:0];
        end
    end

    // pad electrical controls, one bit per pin each
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pullup_q <= RST_PULLUP_ENABLE;
            open_drain_q <= RST_OPEN_DRAIN;
            slew_q <= RST_SLEW_LIMIT;
            threshold_q <= RST_INPUT_THRESHOLD;
        end else if (wr_en && lane0) begin
            if (paddr == OFS_PULLUP_ENABLE) begin
                pullup_q <= pwdata[PIN_COUNT-1:0];
            end
            if (paddr == OFS_OPEN_DRAIN) begin
                open_drain_q <= pwdata[PIN_COUNT-1:0];
            end
            if (paddr == OFS_SLEW_LIMIT) begin
                slew_q <= pwdata[PIN_COUNT-1:0];
            end
            // no guard here: a threshold change can glitch inputs, software must idle them
            if (paddr == OFS_INPUT_THRESHOLD) begin
                threshold_q <= pwdata[PIN_COUNT-1:0];
            end
        end
    end

    // one route register per peripheral input
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_int_route_q <= EXT_INT_ROUTE_RST;
            timer_clk_route_q <= TIMER_CLK_ROUTE_RST;
            serial_rx_route_q <= SERIAL_RX_ROUTE_RST;
        end else if (wr_en && lane0) begin
            if (paddr == OFS_EXT_INT_ROUTE) begin
                ext_int_route_q <= pwdata[ROUTE_W-1:0];
            end
            if (paddr == OFS_TIMER_CLK_ROUTE) begin
                timer_clk_route_q <= pwdata[ROUTE_W-1:0];
            end
            if (paddr == OFS_SERIAL_RX_ROUTE) begin
                serial_rx_route_q <= pwdata[ROUTE_W-1:0];
            end
        end
    end

    // pin code space: port n pin k is code n*8+k; this port fills its own slot
    always_comb begin
        all_pins = route_pins;
        for (int i = 0; i < PIN_COUNT; i++) begin
            all_pins[PORT_INDEX*PORT_STRIDE + i] = digital_in[i];
        end
    end

    // unsupported codes just pick some pin; software keeps codes legal
    assign ext_interrupt_in = all_pins[ext_int_route_q];
    assign timer_clock_in = all_pins[timer_clk_route_q];
    assign serial_rx_in = all_pins[serial_rx_route_q];

    // address decode for the error answer
    always_comb begin
        unique case (paddr)
            OFS_PIN_LEVEL, OFS_DIRECTION, OFS_OUTPUT_LATCH, OFS_ANALOG_SELECT,
            OFS_PULLUP_ENABLE, OFS_OPEN_DRAIN, OFS_SLEW_LIMIT, OFS_INPUT_THRESHOLD,
            OFS_EXT_INT_ROUTE, OFS_TIMER_CLK_ROUTE, OFS_SERIAL_RX_ROUTE: addr_hit = 1'b1;
            default: addr_hit = 1'b0;
        endcase
    end
    assign pslverr = psel & penable & ~addr_hit;

    // read data; upper bits, route bits 7-6 and unmapped reads return zero
    always_comb begin
        prdata = 32'h0000_0000;
        if (rd_en) begin
            unique case (paddr)
                OFS_PIN_LEVEL: prdata[PIN_COUNT-1:0] = digital_in;
                OFS_DIRECTION: prdata[PIN_COUNT-1:0] = direction_q;
                OFS_OUTPUT_LATCH: prdata[PIN_COUNT-1:0] = latch_q;
                OFS_ANALOG_SELECT: prdata[PIN_COUNT-1:0] = analog_q;
                OFS_PULLUP_ENABLE: prdata[PIN_COUNT-1:0] = pullup_q;
                OFS_OPEN_DRAIN: prdata[PIN_COUNT-1:0] = open_drain_q;
                OFS_SLEW_LIMIT: prdata[PIN_COUNT-1:0] = slew_q;
                OFS_INPUT_THRESHOLD: prdata[PIN_COUNT-1:0] = threshold_q;
                OFS_EXT_INT_ROUTE: prdata[ROUTE_W-1:0] = ext_int_route_q;
                OFS_TIMER_CLK_ROUTE: prdata[ROUTE_W-1:0] = timer_clk_route_q;
                OFS_SERIAL_RX_ROUTE: prdata[ROUTE_W-1:0] = serial_rx_route_q;
                default: prdata = 32'h0000_0000;
            endcase
        end
    end

endmodule // gpr_port

`default_nettype wire

// [dv/gpr_port_monitor.sv]
// Purpose: concurrent checks on the port block pins
// Assumes: zero-wait APB, pad controls combinational from registers
// Notes: bound onto every gpr_port instance
`timescale 1ns/100ps
`default_nettype none
module gpr_port_monitor
    import gpr_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [gpr_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire gpr_pkg::gpr_pad_sense_t pad_sense,
    input wire gpr_pkg::gpr_pad_ctrl_t pad_ctrl,
    input wire logic [gpr_pkg::PIN_COUNT-1:0] twi_own,
    input wire logic [gpr_pkg::PIN_COUNT-1:0] twi_drive_low,
    input wire logic [gpr_pkg::PIN_COUNT-1:0] ioc_level
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // access decodes; writes without byte strobe 0 leave controls alone except the latch, which a data write still loads
    wire logic rd = psel && penable && !pwrite;
    wire logic wr = psel && penable && pwrite && pstrb[0];
    wire logic pu_wr = wr && paddr == OFS_PULLUP_ENABLE;
    wire logic sl_wr = wr && paddr == OFS_SLEW_LIMIT;
    wire logic [3:0] wlo = pwdata[3:0];
    logic [3:0] ana_q;

    // shadow of analog select, so a pin read is held to the exact digital level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ana_q <= RST_ANALOG_SELECT;
        end else if (wr && paddr == OFS_ANALOG_SELECT) begin
            ana_q <= wlo;
        end
    end

    chk_dir_top_one:
    assert property (rd && paddr == OFS_DIRECTION |-> prdata[3] && prdata[31:4] == 28'h0)
        else $error("direction top bit not one");
    chk_route_upper_zero:
    assert property (rd && paddr >= OFS_EXT_INT_ROUTE && paddr <= OFS_SERIAL_RX_ROUTE
        |-> prdata[31:6] == 26'h0) else $error("route upper bits set");
    chk_top_pin_input:
    assert property (!twi_own[3] |-> !pad_ctrl.drive_en[3]) else $error("pin 3 driven");
    chk_twi_sink_only:
    assert property (((pad_ctrl.drive_en ^ twi_drive_low) & twi_own) == 4'h0
        && (pad_ctrl.drive & pad_ctrl.drive_en & twi_own) == 4'h0) else $error("owned pin");
    chk_latch_drives:
    assert property (wr && paddr == OFS_OUTPUT_LATCH |=>
        ((pad_ctrl.drive ^ $past(wlo)) & pad_ctrl.drive_en & ~twi_own) == 4'h0)
        else $error("driven value not latch");
    chk_ioc_threshold:
    assert property (((ioc_level ^ pad_sense.schmitt) & (ioc_level ^ pad_sense.ttl)) == 4'h0)
        else $error("change level from neither buffer");
    chk_pin_read_masked:
    assert property (rd && paddr == OFS_PIN_LEVEL |-> prdata[3:0] == (ioc_level & ~ana_q)
        && prdata[31:4] == 28'h0) else $error("pin read not sensed level");
    chk_pullup_hold:
    assert property ($changed(pad_ctrl.pullup_en) |-> $past(pu_wr)) else $error("pull-up moved");
    chk_slew_hold:
    assert property ($changed(pad_ctrl.slew_limit) |-> $past(sl_wr)) else $error("slew moved");

    cover property (pu_wr);
    cover property (rd && paddr == OFS_PIN_LEVEL && prdata[3:0] != 4'h0);
    cover property (|(twi_own & twi_drive_low));
endmodule // gpr_port_monitor

bind gpr_port gpr_port_monitor mon (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pad_sense(pad_sense), .pad_ctrl(pad_ctrl), .twi_own(twi_own),
    .twi_drive_low(twi_drive_low), .ioc_level(ioc_level));
`default_nettype wire

// [dv/gpr_pad_model.sv]
// Purpose: pins and outside circuitry seen by the port
// Assumes: weak pull-up loses to any driver
// Notes: ttl_flip mimics a level between the two thresholds
`timescale 1ns/100ps
`default_nettype none
module gpr_pad_model
    import gpr_pkg::*;
(
    input wire gpr_pkg::gpr_pad_ctrl_t pad_ctrl,
    input wire logic [3:0] ext_level,
    input wire logic [3:0] ttl_flip,
    output gpr_pkg::gpr_pad_sense_t pad_sense
);
    logic [3:0] lvl;
    // a driven pin shows its driver, a released one pull-up or outside level
    assign lvl = (pad_ctrl.drive_en & pad_ctrl.drive)
        | (~pad_ctrl.drive_en & (pad_ctrl.pullup_en | ext_level));
    // one driver for the whole struct: schmitt level first, ttl level second
    assign pad_sense = {lvl, lvl ^ ttl_flip};
endmodule // gpr_pad_model
`default_nettype wire

// [dv/gpr_port_test.sv]
// Purpose: self-checking bench for the four-pin port block
// Assumes: APB slave answers by pready, pad model on the far side
// Notes: an idle cycle between transfers keeps driver updates apart
`timescale 1ns/100ps
`default_nettype none
module gpr_port_test;
    import gpr_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic pready, pslverr, ext_in, tmr_in, rx_in, e;
    logic [ADDR_W-1:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic [3:0] pstrb = 4'h0, twi_own = 4'h0, twi_drive_low = 4'h0, ext_level = 4'hF;
    logic [3:0] ttl_flip = 4'h0, ioc_level;
    logic [63:0] route_pins = 64'h20;
    gpr_pad_sense_t pad_sense;
    gpr_pad_ctrl_t pad_ctrl;
    int failures = 0;
    int checks_done = 0;
    logic [31:0] rv [11] = '{32'h0, 32'hF, 32'h0, 32'hF, 32'h0, 32'h0, 32'hF, 32'hF,
        32'h0, 32'h4, 32'h17};

    gpr_port DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pad_sense(pad_sense), .pad_ctrl(pad_ctrl),
        .twi_own(twi_own), .twi_drive_low(twi_drive_low), .ioc_level(ioc_level),
        .route_pins(route_pins), .ext_interrupt_in(ext_in), .timer_clock_in(tmr_in),
        .serial_rx_in(rx_in));
    gpr_pad_model far_side (.pad_ctrl(pad_ctrl), .ext_level(ext_level),
        .ttl_flip(ttl_flip), .pad_sense(pad_sense));

    // 25 MHz bus clock
    always #20 pclk = ~pclk;

    task automatic close_out;
        if (failures == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // setup, then access held until pready, then one idle cycle
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        input logic [3:0] s, output logic [31:0] r, output logic err);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 4'hF, q, e);
    endtask

    task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, 4'hF, q, e);
        cmp(q, exp);
    endtask

    // watchdog: the whole sequence needs about 120 cycles
    initial begin
        repeat (3000) @(posedge pclk);
        failures++;
        close_out();
    end

    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 11; i++) begin
            rchk(12'(4 * i), rv[i]);
        end
        // drivers come on while analog input is still selected
        wr(OFS_DIRECTION, 32'h0);
        rchk(OFS_DIRECTION, 32'h8);
        wr(OFS_OUTPUT_LATCH, 32'h5);
        cmp(32'(pad_ctrl.drive_en), 32'h7);
        cmp(32'(pad_ctrl.drive & 4'h7), 32'h5);
        rchk(OFS_PIN_LEVEL, 32'h0);
        wr(OFS_ANALOG_SELECT, 32'h0);
        rchk(OFS_PIN_LEVEL, 32'hD);
        // no byte strobe: latch takes the sampled pins
        apb(1'b1, OFS_PIN_LEVEL, 32'h0, 4'h0, q, e);
        rchk(OFS_OUTPUT_LATCH, 32'hD);
        wr(OFS_PIN_LEVEL, 32'h2);
        rchk(OFS_OUTPUT_LATCH, 32'h2);
        rchk(OFS_PIN_LEVEL, 32'hA);
        wr(OFS_OPEN_DRAIN, 32'hF);
        cmp(32'(pad_ctrl.drive_en), 32'h5);
        ext_level <= 4'h0;
        wr(OFS_PULLUP_ENABLE, 32'h2);
        cmp(32'(pad_ctrl.pullup_en), 32'h2);
        rchk(OFS_PIN_LEVEL, 32'h2);
        ttl_flip <= 4'h8;
        wr(OFS_INPUT_THRESHOLD, 32'h0); // no input routed here yet
        rchk(OFS_PIN_LEVEL, 32'hA);
        cmp(32'(ioc_level), 32'hA);
        wr(OFS_SLEW_LIMIT, 32'h5);
        cmp(32'(pad_ctrl.slew_limit), 32'h5);
        wr(OFS_DIRECTION, 32'hF);
        cmp(32'(pad_ctrl.drive_en), 32'h0);
        wr(OFS_OPEN_DRAIN, 32'h0);
        twi_own <= 4'h1;
        twi_drive_low <= 4'h1;
        @(posedge pclk);
        cmp(32'(pad_ctrl.drive_en), 32'h1);
        twi_drive_low <= 4'h0;
        @(posedge pclk);
        cmp(32'(pad_ctrl.drive_en), 32'h0);
        wr(OFS_EXT_INT_ROUTE, 32'hC5); // code 5 is a supported pin
        rchk(OFS_EXT_INT_ROUTE, 32'h5);
        wr(OFS_TIMER_CLK_ROUTE, 32'h6);
        wr(OFS_SERIAL_RX_ROUTE, 32'h21);
        cmp(32'({ext_in, tmr_in, rx_in}), 32'h5);
        route_pins <= ~route_pins;
        @(posedge pclk);
        cmp(32'({ext_in, tmr_in, rx_in}), 32'h3);
        apb(1'b0, 12'h02C, 32'h0, 4'hF, q, e);
        cmp(32'(e), 32'h1);
        cmp(q, 32'h0);
        close_out();
    end
endmodule // gpr_port_test
`default_nettype wire
